// >>> iwp_map.svh
// Notes on behaviour
// - idle, no sysclk: stop sysclk, keep timebase/sub
// - idle no sysclk: watchdog runs only on sub
// - idle with sysclk: all clocks keep running
// - idle with sysclk: watchdog cleared, keeps counting
// - idle keeps memory, registers and port states
// - stop sets powered-down, clears timeout flag
// - wake on reset, port A fall, interrupt, overflow
// - reset wake full reset; overflow wake watchdog reset
// - powered-down cleared by power-up or watchdog clear
// - sleeping overflow sets timeout, resets pc/sp only
// - per-pin port A wake enable, resume after stop
// - blocked waking interrupt resumes, stays pending
// - enabled interrupt with free stack serviced at wake
// - flag set before stop cannot wake
// - crystals share one settle counter, high first
// - execute once high oscillator stable flag is set
// - fast wake from watchdog sleep allows low clock
// - peripherals follow system clock to low source
// - watchdog source: sub clock or sysclk/4
// - watchdog divides by 2^8 to 2^15
// - sub clock runs when watchdog enabled
// - one register holds period and enable key
// - stop with idle 0: deep or watchdog sleep
// - disabled only if option off and key 1010
`ifndef IWP_MAP_SVH
`define IWP_MAP_SVH
// ==========================================================
// register offsets
`define IWP_ADDR_MODE 3'h0
`define IWP_ADDR_WATCHDOG_CONTROL_REG 3'h1
`define IWP_ADDR_STATUS 3'h2
`define IWP_ADDR_PORT_A_WAKE_ENABLE 3'h3
`define IWP_ADDR_PEND 3'h4
// ==========================================================
// fields and reset values
`define IWP_MODE_IDLE_SEL 0
`define IWP_MODE_FAST_WAKE 1
`define IWP_MODE_LOW_CLK 2
`define IWP_MODE_RESET 8'h00
`define IWP_WATCHDOG_CONTROL_REG_RESET 8'h7a
`define IWP_WATCHDOG_CONTROL_REG_SYS_IDLE 7
`define IWP_KEY_DISABLE 4'ha
`define IWP_STAT_PDF 0
`define IWP_STAT_TO 1
`define IWP_STAT_HTO 2
`define IWP_STAT_LTO 3
// ==========================================================
// timing counts
`define IWP_SETTLE_COUNT 11'h400
`define IWP_SYS_DIV_MAX 2'h3
`endif

// >>> iwp_osc_model.sv
`timescale 1ns/100ps
module iwp_osc_model
  import iwp_pkg::*;
#(
  parameter int HXT_HALF = 1,
  parameter int SUB_HALF = 1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire iwp_clkctl_t clkctl,
  output logic hxt_tick_pin,
  output logic sub_tick_pin
);
  // ==========================================================
  // crystals
  // a stopped crystal parks low; the controller gets no free ticks
  int hxt_cnt;
  int sub_cnt;
  wire logic sub_on = clkctl.lxt_enable | clkctl.subclk_run;
  always @(posedge clk)
  begin
    hxt_cnt <= (reset || !clkctl.hxt_enable || hxt_cnt == HXT_HALF - 1) ? 0 : hxt_cnt + 1;
    if (reset || !clkctl.hxt_enable)
      hxt_tick_pin <= 1'b0;
    else if (hxt_cnt == HXT_HALF - 1)
      hxt_tick_pin <= !hxt_tick_pin;
    sub_cnt <= (reset || !sub_on || sub_cnt == SUB_HALF - 1) ? 0 : sub_cnt + 1;
    if (reset || !sub_on)
      sub_tick_pin <= 1'b0;
    else if (sub_cnt == SUB_HALF - 1)
      sub_tick_pin <= !sub_tick_pin;
  end
endmodule : iwp_osc_model

// >>> iwp_pkg.sv
package iwp_pkg;
  typedef enum logic [2:0] {
    IWP_RUN = 3'h0,
    IWP_IDLE_NO_SYSCLK = 3'h1,
    IWP_IDLE_WITH_SYSCLK = 3'h2,
    IWP_DEEP_SLEEP = 3'h3,
    IWP_WATCHDOG_SLEEP = 3'h4,
    IWP_SETTLE = 3'h5
  } iwp_state_t;

  typedef struct packed {
    logic wdt_enable_opt;
    logic wdt_src_sys;
    logic sub_from_lxt;
    logic lvd_enable;
  } iwp_cfg_t;

  typedef struct packed {
    logic sysclk_run;
    logic timebase_run;
    logic subclk_run;
    logic sysclk_low_sel;
    logic hxt_enable;
    logic lxt_enable;
  } iwp_clkctl_t;
endpackage : iwp_pkg

// >>> iwp_power_ctrl.sv
`timescale 1ns/100ps
`include "iwp_map.svh"
module iwp_power_ctrl
  import iwp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire iwp_cfg_t cfg,
  input wire logic halt_exec,
  input wire logic clr_wdt,
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_enable,
  input wire logic stack_full,
  input wire logic ext_reset_n,
  input wire logic [7:0] port_a_pin,
  input wire logic hxt_tick_pin,
  input wire logic sub_tick_pin,
  output iwp_clkctl_t clkctl,
  output logic cpu_halt,
  output logic ports_hold,
  output logic full_reset,
  output logic wdt_reset,
  output logic [7:0] irq_take,
  output logic [7:0] irq_pending
);

  // ==========================================================
  // pin synchronisers
  logic [7:0] pa_s1;
  logic [7:0] pa_s2;
  logic [7:0] pa_s3;
  logic [2:0] ext_s;
  logic [2:0] hxt_s;
  logic [2:0] sub_s;

  // block clock stays on, so edges are seen while sysclk is stopped
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pa_s1 <= 8'hff;
      pa_s2 <= 8'hff;
      pa_s3 <= 8'hff;
      ext_s <= 3'h7;
      hxt_s <= 3'h0;
      sub_s <= 3'h0;
    end
    else
    begin
      pa_s1 <= port_a_pin;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
      ext_s <= {ext_s[1:0], ext_reset_n};
      hxt_s <= {hxt_s[1:0], hxt_tick_pin};
      sub_s <= {sub_s[1:0], sub_tick_pin};
    end
  end

  wire [7:0] pa_fall = pa_s3 & ~pa_s2;
  wire ext_fall = ext_s[2] & ~ext_s[1];
  wire hxt_tick = hxt_s[1] & ~hxt_s[2];
  wire sub_tick = sub_s[1] & ~sub_s[2];

  // ==========================================================
  // software registers
  logic [7:0] mode_control_reg;
  logic [7:0] watchdog_control_reg;
  logic [7:0] port_a_wake_enable;
  logic powered_down_flag;
  logic watchdog_timeout_flag;
  logic high_osc_stable_flag;
  logic low_osc_stable;
  iwp_state_t state;
  iwp_state_t next_state;

  wire idle_select = mode_control_reg[`IWP_MODE_IDLE_SEL];
  wire fast_wakeup_enable = mode_control_reg[`IWP_MODE_FAST_WAKE];
  wire sysclk_in_idle = watchdog_control_reg[`IWP_WATCHDOG_CONTROL_REG_SYS_IDLE];
  wire [2:0] timeout_divider_select = watchdog_control_reg[6:4];
  wire [3:0] watchdog_enable_key = watchdog_control_reg[3:0];
  wire wdt_on = cfg.wdt_enable_opt | (watchdog_enable_key != `IWP_KEY_DISABLE);
  wire running = (state == IWP_RUN);
  wire halt_go = halt_exec & running;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_control_reg <= `IWP_MODE_RESET;
      watchdog_control_reg <= `IWP_WATCHDOG_CONTROL_REG_RESET;
      port_a_wake_enable <= 8'h00;
    end
    else if (wr)
    begin
      if (addr == `IWP_ADDR_MODE)
        mode_control_reg <= wdata;
      if (addr == `IWP_ADDR_WATCHDOG_CONTROL_REG)
        watchdog_control_reg <= wdata;
      if (addr == `IWP_ADDR_PORT_A_WAKE_ENABLE)
        port_a_wake_enable <= wdata;
    end
  end

  wire [7:0] status_word = {4'h0, low_osc_stable, high_osc_stable_flag,
                            watchdog_timeout_flag, powered_down_flag};
  logic [7:0] next_rdata;
  always_comb
  begin
    case (addr)
      `IWP_ADDR_MODE: next_rdata = mode_control_reg;
      `IWP_ADDR_WATCHDOG_CONTROL_REG: next_rdata = watchdog_control_reg;
      `IWP_ADDR_STATUS: next_rdata = status_word;
      `IWP_ADDR_PORT_A_WAKE_ENABLE: next_rdata = port_a_wake_enable;
      `IWP_ADDR_PEND: next_rdata = irq_pending;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata <= 8'h00;
    else
      rdata <= rd ? next_rdata : 8'h00;
  end

  // ==========================================================
  // watchdog
  function automatic logic [14:0] wdt_limit(input logic [2:0] sel);
    wdt_limit = 15'(({8'h0, 8'hff} << sel) | 16'h00ff);
  endfunction : wdt_limit

  logic [1:0] sys_div;
  logic [14:0] wdt_cnt;
  wire sys_tick = clkctl.sysclk_low_sel ? sub_tick : 1'b1;
  wire sys_quarter = sys_tick & (sys_div == `IWP_SYS_DIV_MAX);
  wire src_tick = cfg.wdt_src_sys ? sys_quarter : sub_tick;
  logic wdt_counts;
  always_comb
  begin
    case (state)
      IWP_IDLE_NO_SYSCLK: wdt_counts = !cfg.wdt_src_sys;
      IWP_WATCHDOG_SLEEP: wdt_counts = !cfg.wdt_src_sys;
      IWP_DEEP_SLEEP: wdt_counts = 1'b0;
      default: wdt_counts = 1'b1;
    endcase
  end
  wire wdt_step = wdt_on & wdt_counts & src_tick;
  wire wdt_ovf = wdt_step & (wdt_cnt == wdt_limit(timeout_divider_select));
  wire wdt_clear = halt_go | clr_wdt | wdt_ovf | ~wdt_on;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sys_div <= 2'h0;
      wdt_cnt <= 15'h0;
    end
    else
    begin
      if (sys_tick)
        sys_div <= sys_div + 2'h1;
      if (wdt_clear)
        wdt_cnt <= 15'h0;
      else if (wdt_step)
        wdt_cnt <= wdt_cnt + 15'h1;
    end
  end

  // ==========================================================
  // wake sources
  logic [7:0] irq_armed;
  wire asleep = !running && (state != IWP_SETTLE);
  wire [7:0] irq_wake = irq_req & irq_armed;
  wire pa_wake = |(pa_fall & port_a_wake_enable);
  wire wake = asleep & (pa_wake | (|irq_wake) | wdt_ovf);
  wire [7:0] serviceable = irq_enable & {8{~stack_full}};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq_armed <= 8'h00;
    else if (halt_go)
      irq_armed <= ~irq_req;
  end

  // ==========================================================
  // shared oscillator settle counter
  logic [10:0] settle_cnt;
  logic settle_low;
  wire hxt_needed = (state == IWP_SETTLE);
  wire settle_done = (settle_cnt == `IWP_SETTLE_COUNT - 11'h1);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      settle_cnt <= 11'h0;
      settle_low <= 1'b0;
      high_osc_stable_flag <= 1'b0;
      low_osc_stable <= 1'b0;
    end
    else if (state == IWP_DEEP_SLEEP)
    begin
      settle_cnt <= 11'h0;
      settle_low <= 1'b0;
      high_osc_stable_flag <= 1'b0;
      low_osc_stable <= 1'b0;
    end
    else if (!high_osc_stable_flag)
    begin
      if (hxt_tick)
        settle_cnt <= settle_done ? 11'h0 : settle_cnt + 11'h1;
      if (hxt_tick & settle_done)
      begin
        high_osc_stable_flag <= 1'b1;
        settle_low <= 1'b1;
      end
    end
    else if (settle_low & !low_osc_stable)
    begin
      if (sub_tick)
        settle_cnt <= settle_cnt + 11'h1;
      if (sub_tick & settle_done)
        low_osc_stable <= 1'b1;
    end
  end

  // ==========================================================
  // power mode sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      IWP_RUN:
        if (halt_go)
        begin
          if (idle_select)
            next_state = sysclk_in_idle ? IWP_IDLE_WITH_SYSCLK : IWP_IDLE_NO_SYSCLK;
          else
            next_state = (wdt_on | cfg.lvd_enable) ? IWP_WATCHDOG_SLEEP : IWP_DEEP_SLEEP;
        end
      IWP_DEEP_SLEEP:
        if (wake)
          next_state = IWP_SETTLE;
      IWP_WATCHDOG_SLEEP:
        if (wake)
          next_state = fast_wakeup_enable ? IWP_RUN : IWP_SETTLE;
      IWP_IDLE_NO_SYSCLK, IWP_IDLE_WITH_SYSCLK:
        if (wake)
          next_state = high_osc_stable_flag ? IWP_RUN : IWP_SETTLE;
      IWP_SETTLE:
        if (high_osc_stable_flag)
          next_state = IWP_RUN;
      default: next_state = IWP_RUN;
    endcase
  end

  logic fast_low;
  wire fast_wake = (state == IWP_WATCHDOG_SLEEP) & wake & fast_wakeup_enable;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= IWP_SETTLE;
      fast_low <= 1'b0;
    end
    else if (ext_fall)
    begin
      state <= IWP_SETTLE;
      fast_low <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (fast_wake)
        fast_low <= 1'b1;
      else if (high_osc_stable_flag)
        fast_low <= 1'b0;
    end
  end

  // ==========================================================
  // status flags
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      powered_down_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end
    else
    begin
      if (halt_go)
        powered_down_flag <= 1'b1;
      else if (clr_wdt)
        powered_down_flag <= 1'b0;
      if (wdt_ovf)
        watchdog_timeout_flag <= 1'b1;
      else if (halt_go)
        watchdog_timeout_flag <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt pending and response
  logic [7:0] next_pending;
  logic [7:0] next_take;
  always_comb
  begin
    next_take = 8'h00;
    next_pending = irq_pending & ~irq_take;
    if (asleep & (|irq_wake))
    begin
      next_take = irq_wake & serviceable;
      next_pending = next_pending | (irq_wake & ~serviceable);
    end
    else if (running)
      next_take = irq_pending & ~irq_take & serviceable;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_pending <= 8'h00;
      irq_take <= 8'h00;
    end
    else
    begin
      irq_pending <= next_pending;
      irq_take <= next_take;
    end
  end

  // ==========================================================
  // clock and core control
  iwp_clkctl_t next_clk;
  wire sub_needed = wdt_on | cfg.lvd_enable;
  always_comb
  begin
    next_clk.sysclk_run = (next_state == IWP_RUN) | (next_state == IWP_IDLE_WITH_SYSCLK);
    next_clk.timebase_run = (next_state == IWP_RUN) | (next_state == IWP_IDLE_NO_SYSCLK)
                            | (next_state == IWP_IDLE_WITH_SYSCLK);
    next_clk.subclk_run = (next_state == IWP_IDLE_NO_SYSCLK) | (next_state == IWP_IDLE_WITH_SYSCLK)
                          | ((next_state != IWP_DEEP_SLEEP) & sub_needed);
    next_clk.sysclk_low_sel = mode_control_reg[`IWP_MODE_LOW_CLK] | fast_low | fast_wake;
    next_clk.hxt_enable = next_clk.sysclk_run | hxt_needed | (next_state == IWP_SETTLE);
    next_clk.lxt_enable = next_clk.subclk_run & cfg.sub_from_lxt;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clkctl <= '0;
      cpu_halt <= 1'b1;
      ports_hold <= 1'b0;
      full_reset <= 1'b1;
      wdt_reset <= 1'b0;
    end
    else
    begin
      clkctl <= next_clk;
      cpu_halt <= (next_state != IWP_RUN);
      ports_hold <= (next_state != IWP_RUN) & (next_state != IWP_SETTLE);
      full_reset <= ext_fall;
      wdt_reset <= wdt_ovf;
    end
  end

endmodule : iwp_power_ctrl

// >>> iwp_power_ctrl_monitor.sv
`timescale 1ns/100ps
module iwp_power_monitor
  import iwp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire iwp_cfg_t cfg,
  input wire logic halt_exec,
  input wire logic [7:0] irq_enable,
  input wire logic stack_full,
  input wire logic ext_reset_n,
  input wire logic [7:0] port_a_pin,
  input wire logic hxt_tick_pin,
  input wire iwp_clkctl_t clkctl,
  input wire logic cpu_halt,
  input wire logic ports_hold,
  input wire logic full_reset,
  input wire logic wdt_reset,
  input wire logic [7:0] irq_take
);
  // ==========================================================
  // shadows of the mode bits
  logic idle_sel;
  logic system_clock;
  logic in_idle_with_sysclk;
  logic hxt_d;
  logic [3:0] key;
  logic [7:0] wake_en;
  logic [11:0] hxt_cnt;
  logic [3:0] since_ext;
  wire logic deep_cond = !idle_sel && key == 4'ha && !cfg.wdt_enable_opt && !cfg.lvd_enable;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      idle_sel <= 1'b0;
      system_clock <= 1'b0;
      key <= 4'ha;
      wake_en <= 8'h00;
    end
    else if (wr)
    begin
      if (addr == 3'h0) idle_sel <= wdata[0];
      if (addr == 3'h1) {system_clock, key} <= {wdata[7], wdata[3:0]};
      if (addr == 3'h3) wake_en <= wdata;
    end
  end
  // raw tick count is an upper bound on what the synced logic sees
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      {in_idle_with_sysclk, hxt_d, hxt_cnt, since_ext} <= '0;
    end
    else
    begin
      hxt_d <= hxt_tick_pin;
      in_idle_with_sysclk <= (halt_exec && !cpu_halt) ? idle_sel && system_clock : in_idle_with_sysclk && cpu_halt;
      since_ext <= !ext_reset_n ? 4'h0 : since_ext + {3'h0, since_ext != 4'hf};
      if (halt_exec && !cpu_halt && deep_cond) hxt_cnt <= 12'h000;
      else if (hxt_tick_pin && !hxt_d && hxt_cnt != 12'hfff) hxt_cnt <= hxt_cnt + 12'h001;
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_halt_run;
    halt_exec && !cpu_halt;
  endsequence
  sequence s_wake_fall;
    cpu_halt && in_idle_with_sysclk && |(wake_en & $past(port_a_pin) & ~port_a_pin);
  endsequence
  a_idle_no_sysclk_clocks:
    assert property (s_halt_run ##0 (idle_sel && !system_clock) |=> !clkctl.sysclk_run && clkctl.timebase_run && clkctl.subclk_run)
    else $error("idle without sysclk has wrong clocks");
  a_idle_with_sysclk_clocks:
    assert property (s_halt_run ##0 (idle_sel && system_clock) |=> clkctl.sysclk_run && clkctl.timebase_run && clkctl.subclk_run)
    else $error("idle with sysclk has wrong clocks");
  a_halt_hold_ports:
    assert property (s_halt_run |=> cpu_halt && ports_hold)
    else $error("halt did not stop core and hold ports");
  a_deep_all_off:
    assert property (s_halt_run ##0 deep_cond |=> !clkctl.subclk_run && !clkctl.sysclk_run && !clkctl.timebase_run)
    else $error("deep sleep left a clock running");
  a_port_wake:
    assert property (s_wake_fall |-> ##[1:8] !cpu_halt)
    else $error("enabled port fall did not resume");
  a_exec_settled:
    assert property ($fell(cpu_halt) |-> hxt_cnt >= 12'd1024)
    else $error("execution before high crystal settled");
  a_full_from_pin:
    assert property (full_reset |-> since_ext < 4'd12)
    else $error("full reset without external reset");
  a_wdt_pc_only:
    assert property (wdt_reset |-> !full_reset ##1 !wdt_reset)
    else $error("watchdog wake not a single pc reset pulse");
  a_take_allowed:
    assert property (irq_take != 8'h00 |-> !$past(stack_full) && (irq_take & ~$past(irq_enable)) == 8'h00)
    else $error("interrupt taken while blocked");
endmodule : iwp_power_monitor

bind iwp_power_ctrl iwp_power_monitor i_iwp_power_monitor (.*);

// >>> tb_idle_wakeup_power_control.sv
`timescale 1ns/100ps
module tb_idle_wakeup_power_control
  import iwp_pkg::*;
;
  logic clk;
  logic reset = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  iwp_cfg_t cfg = 4'h2;
  logic halt_exec = 1'b0;
  logic clr_wdt = 1'b0;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_enable = 8'h00;
  logic stack_full = 1'b0;
  logic ext_reset_n = 1'b1;
  logic [7:0] port_a_pin = 8'hff;
  logic hxt_tick_pin;
  logic sub_tick_pin;
  iwp_clkctl_t clkctl;
  logic cpu_halt;
  logic ports_hold;
  logic full_reset;
  logic wdt_reset;
  logic [7:0] irq_take;
  logic [7:0] irq_pending;
  logic [10:0] watch;
  int err_count = 0;
  int n_compared = 0;
  assign watch = {irq_take, full_reset, wdt_reset, ~cpu_halt};
  iwp_power_ctrl i_iwp_power_ctrl (.*);
  iwp_osc_model i_iwp_osc_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // tasks
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    n_compared++;
    if ((got & msk) !== (exp & msk))
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] msk);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, msk);
  endtask : reg_rd
  task automatic halt_cmd();
    @(posedge clk);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    #1;
    chk({6'h00, cpu_halt, ports_hold}, 8'h03, 8'h03);
  endtask : halt_cmd
  // index: 0 running, 1 watchdog reset, 2 full reset, 3+n take n
  task automatic wait_on(input int sel, input int lim);
    int i;
    for (i = 0; i < lim && watch[sel] !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (i == lim)
    begin
      $display("mismatch at %0t: wait %0d timed out", $time, sel);
      err_count++;
      close_out();
    end
  endtask : wait_on
  // ==========================================================
  // sequence
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    chk({6'h00, cpu_halt, full_reset}, 8'h03, 8'h03);
    @(posedge clk) reset <= 1'b0;
    wait_on(0, 4000);
    reg_rd(3'h2, 8'h04, 8'h07);
    reg_rd(3'h1, 8'h7a, 8'hff);
    reg_rd(3'h5, 8'h00, 8'hff);
    reg_wr(3'h3, 8'h01);
    reg_wr(3'h0, 8'h01);
    reg_wr(3'h1, 8'hfa);
    halt_cmd();
    chk({2'b00, clkctl}, 8'h38, 8'h38);
    reg_rd(3'h2, 8'h01, 8'h03);
    // pin 1 has no wake enable, so its fall must be ignored
    @(posedge clk) port_a_pin <= 8'hfd;
    repeat (12) @(posedge clk);
    chk({7'h00, cpu_halt}, 8'h01, 8'h01);
    @(posedge clk) port_a_pin <= 8'hfc;
    wait_on(0, 12);
    @(posedge clk) port_a_pin <= 8'hff;
    reg_wr(3'h1, 8'h7a);
    halt_cmd();
    chk({2'b00, clkctl}, 8'h18, 8'h38);
    @(posedge clk) irq_enable <= 8'h04;
    irq_req <= 8'h04;
    wait_on(5, 3000);
    @(posedge clk) irq_req <= 8'h00;
    wait_on(0, 3000);
    @(posedge clk) clr_wdt <= 1'b1;
    @(posedge clk) clr_wdt <= 1'b0;
    reg_rd(3'h2, 8'h00, 8'h01);
    // stale request on 4; waking request on 3 meets a full stack
    @(posedge clk) irq_enable <= 8'h08;
    stack_full <= 1'b1;
    irq_req <= 8'h10;
    halt_cmd();
    repeat (20) @(posedge clk);
    chk({7'h00, cpu_halt}, 8'h01, 8'h01);
    @(posedge clk) irq_req <= 8'h18;
    wait_on(0, 3000);
    chk(irq_pending, 8'h08, 8'h08);
    chk(irq_take, 8'h00, 8'hff);
    @(posedge clk) stack_full <= 1'b0;
    wait_on(6, 20);
    @(posedge clk) irq_req <= 8'h00;
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h1, 8'h05);
    halt_cmd();
    chk({2'b00, clkctl}, 8'h08, 8'h28);
    wait_on(1, 3000);
    chk({7'h00, full_reset}, 8'h00, 8'h01);
    wait_on(0, 4000);
    reg_wr(3'h1, 8'h7a);
    reg_rd(3'h2, 8'h02, 8'h02);
    // fast wake from watchdog sleep resumes at once on the low clock
    reg_wr(3'h0, 8'h02);
    reg_wr(3'h1, 8'h05);
    halt_cmd();
    chk({2'b00, clkctl}, 8'h08, 8'h28);
    @(posedge clk) port_a_pin <= 8'hfe;
    wait_on(0, 12);
    chk({2'b00, clkctl}, 8'h04, 8'h04);
    @(posedge clk) port_a_pin <= 8'hff;
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h1, 8'h7a);
    halt_cmd();
    chk({2'b00, clkctl}, 8'h00, 8'h38);
    @(posedge clk) ext_reset_n <= 1'b0;
    wait_on(2, 20);
    @(posedge clk) ext_reset_n <= 1'b1;
    wait_on(0, 4000);
    close_out();
  end
endmodule : tb_idle_wakeup_power_control
